// ### verilog/pmc_power_mode_controller.sv
// power-mode controller: run, wait, stop, partial stop and very-low-power modes
// assumes sleep requests and wake interrupts synchronous to i_clk
//
// Summary of operation
// - wait-for-interrupt enters wait when deep-sleep select is clear, stop when it is set.
// - normal run and very-low-power run each own a wait mode and a stop mode.
// - pin states are held unchanged in every non-run power mode.
// - in normal wait the core sleeps, peripherals keep clocks, an interrupt wakes the core.
// - normal stop is static, retains registers, keeps the voltage detector, ends on interrupt.
// - partial stop two gates core and system clocks, bus clock and its users keep running.
// - partial stop one gates core, system and bus clocks, all bus users stop, regulator stays.
// - very-low-power run uses 1 MHz flash access, low-power regulator, detector off.
// - very-low-power run can select an internal 4 MHz oscillator for the core.
// - very-low-power wait keeps the low-power run setup with the core asleep until interrupt.
// - very-low-power stop is static with the voltage detector off.
// - in very-low-power stop the converter, pin interrupts, timer, clock and comparator live.
// - with the converter continuous, biasing is off in very-low-power run, wait and stop.
// - radio in very-low-power run is allowed only with the converter continuous.
`timescale 1ns/1ps

module pwrm_power_mode_controller (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	// core sleep requests
	input  wire logic       i_wait_for_interrupt_instr,
	input  wire logic       i_deep_sleep_select,
	input  wire logic       i_wake_irq,
	// mode configuration
	input  wire logic       i_vlp_run_req,
	input  wire logic [1:0] i_pstop_sel,
	input  wire logic       i_lp_osc_sel,
	input  wire logic       i_dcdc_continuous,
	input  wire logic       i_radio_req,
	// clock gating
	output logic            o_core_clk_en,
	output logic            o_sys_clk_en,
	output logic            o_bus_clk_en,
	output logic            o_bus_users_stop,
	output logic            o_periph_clk_en,
	output logic            o_flash_clk_en,
	output logic            o_core_lp_osc_sel,
	// analog and supply
	output logic            o_regulator_lp,
	output logic            o_low_voltage_detector_en,
	output logic            o_bias_en,
	output logic            o_radio_allowed,
	output logic            o_lp_wake_sources_en,
	output logic            o_io_hold,
	// status
	output logic [8:0]      o_mode
);

	// ***************************************************
	// mode state machine
	// ***************************************************
	pwrm_pkg::pwrm_state_t state_ff;
	pwrm_pkg::pwrm_state_t nxt_state;

	// true in any of the four very-low-power states
	function automatic logic is_vlp(input pwrm_pkg::pwrm_state_t s);
		is_vlp = (s == pwrm_pkg::ST_VLP_RUN) || (s == pwrm_pkg::ST_VLP_WAIT) ||
		         (s == pwrm_pkg::ST_VLP_STOP) || (s == pwrm_pkg::ST_VLP_PS);
	endfunction

	// true in the two states in which the core executes
	function automatic logic is_run(input pwrm_pkg::pwrm_state_t s);
		is_run = (s == pwrm_pkg::ST_RUN) || (s == pwrm_pkg::ST_VLP_RUN);
	endfunction

	// a sleep request wins over a run-mode change in the same cycle
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			pwrm_pkg::ST_RUN: begin
				if (i_wait_for_interrupt_instr) begin
					if (!i_deep_sleep_select)
						nxt_state = pwrm_pkg::ST_WAIT;
					else if (i_pstop_sel == pwrm_pkg::PSTOP_LV2)
						nxt_state = pwrm_pkg::ST_PART_STOP2;
					else if (i_pstop_sel == pwrm_pkg::PSTOP_LV1)
						nxt_state = pwrm_pkg::ST_PART_STOP1;
					else
						nxt_state = pwrm_pkg::ST_STOP;
				end else if (i_vlp_run_req) begin
					nxt_state = pwrm_pkg::ST_VLP_RUN;
				end
			end
			pwrm_pkg::ST_VLP_RUN: begin
				if (i_wait_for_interrupt_instr) begin
					if (!i_deep_sleep_select)
						nxt_state = pwrm_pkg::ST_VLP_WAIT;
					else if (i_pstop_sel != pwrm_pkg::PSTOP_NONE)
						nxt_state = pwrm_pkg::ST_VLP_PS;
					else
						nxt_state = pwrm_pkg::ST_VLP_STOP;
				end else if (!i_vlp_run_req) begin
					nxt_state = pwrm_pkg::ST_RUN;
				end
			end
			pwrm_pkg::ST_WAIT,
			pwrm_pkg::ST_STOP,
			pwrm_pkg::ST_PART_STOP2,
			pwrm_pkg::ST_PART_STOP1: begin
				if (i_wake_irq)
					nxt_state = pwrm_pkg::ST_RUN;
			end
			pwrm_pkg::ST_VLP_WAIT,
			pwrm_pkg::ST_VLP_STOP,
			pwrm_pkg::ST_VLP_PS: begin
				if (i_wake_irq)
					nxt_state = pwrm_pkg::ST_VLP_RUN;
			end
			default: nxt_state = pwrm_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset)
			state_ff <= pwrm_pkg::ST_RUN;
		else
			state_ff <= nxt_state;
	end

	// partial-stop level kept while in the very-low-power partial stop,
	// so a later change of the select input cannot move the bus clock
	logic pstop_lv1_ff;
	always_ff @(posedge i_clk) begin
		if (i_reset)
			pstop_lv1_ff <= 1'b0;
		else if (state_ff == pwrm_pkg::ST_VLP_RUN && i_wait_for_interrupt_instr)
			pstop_lv1_ff <= (i_pstop_sel == pwrm_pkg::PSTOP_LV1);
	end

	// ***************************************************
	// flash access divider for very-low-power modes
	// ***************************************************
	// one strobe per flash slot; held cleared outside low-power modes
	logic [4:0] flash_div_ff;
	logic       flash_tick;
	assign flash_tick = (flash_div_ff == 5'(pwrm_pkg::FLASH_DIV_CYC - 1));

	always_ff @(posedge i_clk) begin
		if (i_reset || flash_tick || !is_vlp(state_ff))
			flash_div_ff <= pwrm_pkg::RESET_DIV;
		else
			flash_div_ff <= flash_div_ff + 5'h01;
	end

	// ***************************************************
	// next-mode decodes
	// ***************************************************
	logic sleeping;
	logic static_stop;
	logic vlp_next;
	logic part_lv1_next;
	assign vlp_next      = is_vlp(nxt_state);
	// on entry the level comes from the select input, afterwards from the latch
	assign part_lv1_next = (nxt_state == pwrm_pkg::ST_PART_STOP1) ||
	                       (nxt_state == pwrm_pkg::ST_VLP_PS &&
	                        (state_ff == pwrm_pkg::ST_VLP_PS ? pstop_lv1_ff :
	                         i_pstop_sel == pwrm_pkg::PSTOP_LV1));
	assign sleeping      = !is_run(nxt_state);
	assign static_stop   = (nxt_state == pwrm_pkg::ST_STOP) ||
	                       (nxt_state == pwrm_pkg::ST_VLP_STOP);

	// ***************************************************
	// clock gates, registered from the next mode
	// ***************************************************
	// decoding nxt_state lets every gate change at the same edge as o_mode
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_core_clk_en    <= 1'b1;
			o_sys_clk_en     <= 1'b1;
			o_bus_clk_en     <= 1'b1;
			o_bus_users_stop <= 1'b0;
			o_periph_clk_en  <= 1'b1;
		end else begin
			// core gated whenever asleep; wake restores it
			o_core_clk_en    <= !sleeping;
			o_sys_clk_en     <= (nxt_state == pwrm_pkg::ST_WAIT) ||
			                    (nxt_state == pwrm_pkg::ST_VLP_WAIT) || !sleeping;
			// bus clock survives partial stop two, stops in level one and static stop
			o_bus_clk_en     <= !static_stop && !part_lv1_next;
			o_bus_users_stop <= static_stop || part_lv1_next;
			o_periph_clk_en  <= !static_stop && !part_lv1_next;
		end
	end

	// ***************************************************
	// core clock source and mode status
	// ***************************************************
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_core_lp_osc_sel <= 1'b0;
			o_mode            <= pwrm_pkg::ST_RUN;
		end else begin
			// the low-power oscillator is only offered in low-power modes
			o_core_lp_osc_sel <= vlp_next && i_lp_osc_sel;
			o_mode            <= nxt_state;
		end
	end

	// flash strobe: full rate in normal modes, 1 MHz ticks in low-power ones
	assign o_flash_clk_en = is_vlp(state_ff) ? flash_tick : 1'b1;

	// ***************************************************
	// supply, detector, radio and pin hold
	// ***************************************************
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_regulator_lp            <= 1'b0;
			o_low_voltage_detector_en <= 1'b1;
			o_bias_en                 <= 1'b1;
			o_radio_allowed           <= 1'b0;
			o_lp_wake_sources_en      <= 1'b0;
			o_io_hold                 <= 1'b0;
		end else begin
			// regulator stays in its run-mode state through partial stops
			o_regulator_lp            <= vlp_next;
			// detector kept in normal stop, off in all low-power modes
			o_low_voltage_detector_en <= !vlp_next;
			o_bias_en                 <= !(vlp_next && i_dcdc_continuous);
			o_radio_allowed           <= i_radio_req &&
			                             (!vlp_next || i_dcdc_continuous);
			o_lp_wake_sources_en      <= (nxt_state == pwrm_pkg::ST_VLP_STOP);
			// pins frozen while any non-run mode is active
			o_io_hold                 <= sleeping;
		end
	end

endmodule // pwrm_power_mode_controller

// ### verilog/pmc_pkg.sv
// package for the power-mode controller: mode encodings and timing constants
// assumes a single 25 MHz system clock domain
package pwrm_pkg;

	// ***************************************************
	// mode state encodings (one-hot)
	// ***************************************************
	typedef enum logic [8:0] {
		ST_RUN        = 9'h001,
		ST_WAIT       = 9'h002,
		ST_STOP       = 9'h004,
		ST_PART_STOP2 = 9'h008,
		ST_PART_STOP1 = 9'h010,
		ST_VLP_RUN    = 9'h020,
		ST_VLP_WAIT   = 9'h040,
		ST_VLP_STOP   = 9'h080,
		ST_VLP_PS     = 9'h100
	} pwrm_state_t;

	// partial-stop request codes for stop entry
	localparam logic [1:0] PSTOP_NONE = 2'h0;
	localparam logic [1:0] PSTOP_LV2  = 2'h2;
	localparam logic [1:0] PSTOP_LV1  = 2'h1;

	// ***************************************************
	// clock figures
	// ***************************************************
	localparam int SYS_CLK_HZ       = 25000000;
	localparam int VLP_FLASH_HZ     = 1000000;
	localparam int VLP_CORE_HZ      = 4000000;
	// divide ratios derived from the system clock; longest time rounds down
	localparam int FLASH_DIV_CYC    = SYS_CLK_HZ / VLP_FLASH_HZ;
	localparam int CORE_DIV_CYC     = SYS_CLK_HZ / VLP_CORE_HZ;
	localparam logic [4:0] RESET_DIV = 5'h00;

endpackage

// ### sim/pmc_power_mode_controller_chk.sv
// checker for the power-mode controller, bound onto its ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module pwrm_power_mode_controller_chk (
	input logic i_clk,
	input logic i_reset,
	input logic i_wait_for_interrupt_instr,
	input logic i_deep_sleep_select,
	input logic i_wake_irq,
	input logic i_dcdc_continuous,
	input logic o_core_clk_en,
	input logic o_sys_clk_en,
	input logic o_bus_clk_en,
	input logic o_bus_users_stop,
	input logic o_periph_clk_en,
	input logic o_flash_clk_en,
	input logic o_regulator_lp,
	input logic o_low_voltage_detector_en,
	input logic o_bias_en,
	input logic o_lp_wake_sources_en,
	input logic o_io_hold,
	input logic [8:0] o_mode
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	enter_wait_a: assert property (o_mode == 9'h001 && i_wait_for_interrupt_instr
		&& !i_deep_sleep_select |=> o_mode == 9'h002) else $error("no wait entry");
	wake_back_a: assert property (o_mode == 9'h040 && i_wake_irq |=> o_mode == 9'h020)
		else $error("no low-power run return");
	wait_core_a: assert property (o_mode == 9'h002 |-> !o_core_clk_en && o_periph_clk_en)
		else $error("wait clocks wrong");
	pstop_two_a: assert property (o_mode == 9'h008 |-> o_bus_clk_en && !o_sys_clk_en)
		else $error("level two clocks wrong");
	pstop_one_a: assert property (o_mode == 9'h010 |-> o_bus_users_stop && !o_regulator_lp)
		else $error("level one bus runs");
	vlp_stop_a: assert property (o_mode == 9'h080 |-> o_lp_wake_sources_en
		&& !o_low_voltage_detector_en) else $error("low-power stop wrong");
	bias_off_a: assert property (o_mode == 9'h080 && i_dcdc_continuous |=> !o_bias_en)
		else $error("bias left on");
	flash_slow_a: assert property ((o_mode == 9'h020 && o_flash_clk_en) ##1 o_mode == 9'h020
		|-> !o_flash_clk_en) else $error("flash too fast");
	pin_hold_a: assert property (o_mode != 9'h001 && o_mode != 9'h020 |-> o_io_hold)
		else $error("pins not held");
	cover property (o_mode == 9'h010);
	cover property (o_mode == 9'h100);
	cover property (o_mode == 9'h080 ##1 o_mode == 9'h020);
endmodule // pwrm_power_mode_controller_chk
bind pwrm_power_mode_controller pwrm_power_mode_controller_chk pwrm_power_mode_controller_chk_i (
	.i_clk,
	.i_reset,
	.i_wait_for_interrupt_instr,
	.i_deep_sleep_select,
	.i_wake_irq,
	.i_dcdc_continuous,
	.o_core_clk_en,
	.o_sys_clk_en,
	.o_bus_clk_en,
	.o_bus_users_stop,
	.o_periph_clk_en,
	.o_flash_clk_en,
	.o_regulator_lp,
	.o_low_voltage_detector_en,
	.o_bias_en,
	.o_lp_wake_sources_en,
	.o_io_hold,
	.o_mode
);

// ### sim/pmc_core_model.sv
// core model: sleep pulses and wake interrupts
// assumes its tasks are called just after a clock edge
`timescale 1ns/1ps
module pwrm_core_model (
	input  logic i_clk,
	output logic o_wait_for_interrupt_instr,
	output logic o_deep_sleep_select,
	output logic o_wake_irq
);
	initial begin
		o_wait_for_interrupt_instr = 1'h0;
		o_deep_sleep_select = 1'h0;
		o_wake_irq = 1'h0;
	end
	task automatic sleep(input logic d);
		@(posedge i_clk);
		#1 o_wait_for_interrupt_instr = 1'h1;
		o_deep_sleep_select = d;
		@(posedge i_clk);
		#1 o_wait_for_interrupt_instr = 1'h0;
	endtask
	// idle cycles first, so a late wake is exercised too
	task automatic wake(input int n);
		repeat (n + 1) @(posedge i_clk);
		#1 o_wake_irq = 1'h1;
		@(posedge i_clk);
		#1 o_wake_irq = 1'h0;
	endtask
endmodule // pwrm_core_model

// ### sim/pmc_power_mode_controller_test.sv
// self-checking bench for the power-mode controller against a mode model
// assumes the core model drives sleep and wake while the bench drives setup
`timescale 1ns/1ps
module pwrm_power_mode_controller_test;
	logic        i_clk = 1'h0, i_reset = 1'h1, i_vlp_run_req = 1'h0, i_lp_osc_sel = 1'h0;
	logic        i_dcdc_continuous = 1'h0, i_radio_req = 1'h0;
	logic [1:0]  i_pstop_sel = 2'h0;
	logic        i_wait_for_interrupt_instr, i_deep_sleep_select, i_wake_irq;
	logic        o_core_clk_en, o_sys_clk_en, o_bus_clk_en, o_bus_users_stop, o_periph_clk_en;
	logic        o_flash_clk_en, o_core_lp_osc_sel, o_regulator_lp, o_low_voltage_detector_en;
	logic        o_bias_en, o_radio_allowed, o_lp_wake_sources_en, o_io_hold;
	logic [8:0]  o_mode, em;
	logic [16:0] lf = 17'h15083;
	int          n_fail = 0, num_checks = 0;
	wire [11:0]  got = {o_core_clk_en, o_sys_clk_en, o_bus_clk_en, o_periph_clk_en,
		o_bus_users_stop, o_io_hold, o_regulator_lp, o_low_voltage_detector_en, o_bias_en,
		o_radio_allowed, o_lp_wake_sources_en, o_core_lp_osc_sel};
	always #20 i_clk = ~i_clk;
	pwrm_power_mode_controller pwrm_power_mode_controller_i (
		.i_clk, .i_reset, .i_wait_for_interrupt_instr, .i_deep_sleep_select, .i_wake_irq,
		.i_vlp_run_req, .i_pstop_sel, .i_lp_osc_sel, .i_dcdc_continuous, .i_radio_req,
		.o_core_clk_en, .o_sys_clk_en, .o_bus_clk_en, .o_bus_users_stop, .o_periph_clk_en,
		.o_flash_clk_en, .o_core_lp_osc_sel, .o_regulator_lp, .o_low_voltage_detector_en,
		.o_bias_en, .o_radio_allowed, .o_lp_wake_sources_en, .o_io_hold, .o_mode);
	pwrm_core_model pwrm_core_model_i (.i_clk,
		.o_wait_for_interrupt_instr(i_wait_for_interrupt_instr),
		.o_deep_sleep_select(i_deep_sleep_select), .o_wake_irq(i_wake_irq));
	function automatic logic [16:0] lfsr_next(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	function automatic logic [8:0] slp(logic [8:0] m, logic d);
		if (m == 9'h001)
			return !d ? 9'h002 : i_pstop_sel == 2'h2 ? 9'h008 : i_pstop_sel == 2'h1 ? 9'h010 : 9'h004;
		return !d ? 9'h040 : i_pstop_sel == 2'h0 ? 9'h080 : 9'h100;
	endfunction
	function automatic logic [11:0] lv(logic [8:0] m);
		logic v, r, b;
		v = m >= 9'h020;
		r = m == 9'h001 || m == 9'h020;
		b = !(m inside {9'h004, 9'h010, 9'h080} || (m == 9'h100 && i_pstop_sel == 2'h1));
		return {r, m inside {9'h001, 9'h002, 9'h020, 9'h040}, b, b, !b, !r, v, !v,
			!(v && i_dcdc_continuous), i_radio_req && (!v || i_dcdc_continuous),
			m == 9'h080, v && i_lp_osc_sel};
	endfunction
	task automatic chk(input logic [8:0] e);
		num_checks++;
		if ({o_mode, got} !== {e, lv(e)}) begin
			n_fail++;
			$display("MISMATCH %0t mode %h exp %h outs %h", $time, o_mode, e, got);
		end
	endtask
	// normal run: strobe always on; low-power run: one strobe per 1 MHz slot
	task automatic chk_flash(input logic [8:0] m);
		int gap;
		gap = 0;
		num_checks++;
		if (m == 9'h020) begin
			while (o_flash_clk_en !== 1'h1 && gap < 64) begin
				@(posedge i_clk);
				#1 gap++;
			end
			gap = 0;
			do begin
				@(posedge i_clk);
				#1 gap++;
			end while (o_flash_clk_en !== 1'h1 && gap < 64);
			if (gap != pwrm_pkg::SYS_CLK_HZ / pwrm_pkg::VLP_FLASH_HZ) begin
				n_fail++;
				$display("MISMATCH %0t flash strobe gap %0d", $time, gap);
			end
		end else if (o_flash_clk_en !== 1'h1) begin
			n_fail++;
			$display("MISMATCH %0t flash strobe off in normal run", $time);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge i_clk);
		#1 i_reset = 1'h0;
		for (int i = 0; i < 60; i++) begin
			lf = lfsr_next(lf);
			{i_vlp_run_req, i_pstop_sel, i_lp_osc_sel, i_dcdc_continuous, i_radio_req} = lf[5:0];
			repeat (2) @(posedge i_clk);
			#1 em = i_vlp_run_req ? 9'h020 : 9'h001;
			chk(em);
			chk_flash(em);
			pwrm_core_model_i.sleep(lf[6]);
			em = slp(em, lf[6]);
			chk(em);
			pwrm_core_model_i.sleep(!lf[6]);
			chk(em);
			pwrm_core_model_i.wake(lf[8:7]);
			em = em >= 9'h020 ? 9'h020 : 9'h001;
			chk(em);
		end
		// reset in mid-run from a deep sleep must land in run with pins released
		i_vlp_run_req = 1'h0;
		i_radio_req = 1'h0;
		pwrm_core_model_i.sleep(1'h1);
		em = slp(9'h001, 1'h1);
		chk(em);
		i_reset = 1'h1;
		@(posedge i_clk);
		#1 chk(9'h001);
		i_reset = 1'h0;
		repeat (2) @(posedge i_clk);
		#1 chk(9'h001);
		pwrm_core_model_i.sleep(1'h0);
		chk(9'h002);
		pwrm_core_model_i.wake(0);
		chk(9'h001);
		tally_and_finish;
	end
	// 60 rounds of at most about 65 cycles each plus the reset tail, with margin
	initial begin
		repeat (8000) @(posedge i_clk);
		n_fail++;
		tally_and_finish;
	end
endmodule // pwrm_power_mode_controller_test
